/* shared/isp_pkg.sv */
// constants, positions and types of the two-wire slave port
package isp_pkg;
	localparam int ISP_BYTE_W = 8;
	localparam int ISP_CNT_W = 4;
	localparam logic [3:0] ISP_BIT_LAST = 4'h8;
	localparam logic [3:0] ISP_BIT_ACK = 4'h9;
	localparam logic [4:0] ISP_TEN_HI = 5'h1E;
	localparam logic [7:0] ISP_ADDR_RST = 8'h00;
	localparam logic [7:0] ISP_BUF_RST = 8'h00;
	// software event toggles
	localparam int ISP_EV_W = 6;
	localparam int EV_REL_SET = 0;
	localparam int EV_REL_CLR = 1;
	localparam int EV_BUF_WR = 2;
	localparam int EV_BUF_RD = 3;
	localparam int EV_ADR_WR = 4;
	localparam int EV_IRQ_CLR = 5;
	// configuration levels
	localparam int ISP_CFG_W = 6;
	localparam int CFG_ADDRESS_HOLD_ENABLE = 0;
	localparam int CFG_DATA_HOLD_ENABLE = 1;
	localparam int CFG_STR = 2;
	localparam int CFG_SIRQ = 3;
	localparam int CFG_TEN = 4;
	localparam int CFG_ACKD = 5;
	// status word back to the system side
	localparam int ISP_STAT_W = 18;
	localparam int SB_IRQ = 0;
	localparam int SB_REL = 1;
	localparam int SB_BF = 2;
	localparam int SB_ACKST = 3;
	localparam int SB_ACKT = 4;
	localparam int SB_RW = 5;
	localparam int SB_DA = 6;
	localparam int SB_START = 7;
	localparam int SB_STOP = 8;
	localparam int SB_UA = 9;
	localparam int SB_BUF = 10;
	typedef enum logic [1:0] {ISP_IDLE, ISP_ADDR, ISP_RX, ISP_TX} isp_state_t;
endpackage

/* rtl/isp_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module isp_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // isp_sync2

/* rtl/isp_slave.sv */
// two-wire slave port: engine on link_clk, software side on clock
`timescale 1ns/1ps
module isp_slave (
	// system clock and reset
	input wire logic clock,
	input wire logic rstn,
	// link clock and pins
	input wire logic link_clk,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// configuration levels
	input wire logic address_hold_enable,
	input wire logic data_hold_enable,
	input wire logic stretch_enable,
	input wire logic start_irq_enable,
	input wire logic ten_bit_mode,
	input wire logic ack_data_value,
	// software strobes
	input wire logic release_set,
	input wire logic release_clear,
	input wire logic buf_write,
	input wire logic [isp_pkg::ISP_BYTE_W-1:0] buf_wdata,
	input wire logic buf_read,
	input wire logic addr_write,
	input wire logic [isp_pkg::ISP_BYTE_W-1:0] addr_wdata,
	input wire logic irq_clear,
	// status
	output logic port_irq_flag,
	output logic clock_release,
	output logic buffer_full,
	output logic ack_status,
	output logic ack_timing_flag,
	output logic read_write,
	output logic data_not_address,
	output logic start_seen,
	output logic stop_seen,
	output logic update_address_flag,
	output logic [isp_pkg::ISP_BYTE_W-1:0] shift_buffer
);
	import isp_pkg::*;

	// ****************************************
	// software side
	// ****************************************
	logic [ISP_EV_W-1:0] ev_tgl_q;
	logic [ISP_BYTE_W-1:0] txw_q;
	logic [ISP_BYTE_W-1:0] adw_q;
	logic [ISP_STAT_W-1:0] stat_s;

	// each strobe flips a toggle; data words stay put until the next strobe
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ev_tgl_q <= '0;
		end else begin
			ev_tgl_q <= ev_tgl_q ^ {irq_clear, addr_write, buf_read, buf_write, release_clear, release_set};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			txw_q <= ISP_BUF_RST;
			adw_q <= ISP_ADDR_RST;
		end else begin
			if (buf_write) begin
				txw_q <= buf_wdata;
			end
			if (addr_write) begin
				adw_q <= addr_wdata;
			end
		end
	end

	// ****************************************
	// crossings
	// ****************************************
	logic [1:0] pin_s;
	logic [ISP_EV_W+ISP_CFG_W-1:0] ctl_s;
	logic [ISP_STAT_W-1:0] stat_l;

	isp_sync2 #(.WIDTH(2), .RST(2'h3)) u_pin (
		.clk(link_clk),
		.rstn(rstn),
		.d({scl_i, sda_i}),
		.q(pin_s)
	);

	isp_sync2 #(.WIDTH(ISP_EV_W+ISP_CFG_W)) u_ctl (
		.clk(link_clk),
		.rstn(rstn),
		.d({ack_data_value, ten_bit_mode, start_irq_enable, stretch_enable,
			data_hold_enable, address_hold_enable, ev_tgl_q}),
		.q(ctl_s)
	);

	isp_sync2 #(.WIDTH(ISP_STAT_W), .RST(ISP_STAT_W'(1 << SB_REL))) u_stat (
		.clk(clock),
		.rstn(rstn),
		.d(stat_l),
		.q(stat_s)
	);

	assign port_irq_flag = stat_s[SB_IRQ];
	assign clock_release = stat_s[SB_REL];
	assign buffer_full = stat_s[SB_BF];
	assign ack_status = stat_s[SB_ACKST];
	assign ack_timing_flag = stat_s[SB_ACKT];
	assign read_write = stat_s[SB_RW];
	assign data_not_address = stat_s[SB_DA];
	assign start_seen = stat_s[SB_START];
	assign stop_seen = stat_s[SB_STOP];
	assign update_address_flag = stat_s[SB_UA];
	assign shift_buffer = stat_s[SB_BUF +: ISP_BYTE_W];

	// ****************************************
	// link side decode
	// ****************************************
	logic [ISP_EV_W-1:0] ev_prev_q;
	logic [ISP_EV_W-1:0] ev;
	logic [ISP_CFG_W-1:0] cfg;
	logic scl_s;
	logic sda_s;
	logic scl_p_q;
	logic sda_p_q;
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;

	assign ev = ctl_s[ISP_EV_W-1:0] ^ ev_prev_q;
	assign cfg = ctl_s[ISP_EV_W +: ISP_CFG_W];
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ev_prev_q <= '0;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			ev_prev_q <= ctl_s[ISP_EV_W-1:0];
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// edges only from the synchronised copies, never the raw pins
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;

	// ****************************************
	// bit counting and shifting
	// ****************************************
	isp_state_t st_q;
	isp_state_t go_q;
	logic [ISP_CNT_W-1:0] cnt_q;
	logic [ISP_BYTE_W-1:0] sh_q;
	logic [ISP_BYTE_W-1:0] own_q;
	logic fall8;
	logic rise9;
	logic fall9;
	logic busy;

	assign busy = st_q != ISP_IDLE;
	assign fall8 = busy & scl_fall & (cnt_q == ISP_BIT_LAST);
	assign rise9 = busy & scl_rise & (cnt_q == ISP_BIT_LAST);
	assign fall9 = busy & scl_fall & (cnt_q == ISP_BIT_ACK);

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (start_det || fall9) begin
			cnt_q <= '0;
		end else if (busy && scl_rise) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// one register shifts in received bits and out transmitted bits
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			sh_q <= ISP_BUF_RST;
		end else if (st_q == ISP_TX) begin
			if (ev[EV_BUF_WR]) begin
				sh_q <= txw_q;
			end else if (scl_fall && cnt_q != 4'h0 && cnt_q < ISP_BIT_LAST) begin
				sh_q <= {sh_q[ISP_BYTE_W-2:0], 1'b0};
			end
		end else if (busy && scl_rise && cnt_q < ISP_BIT_LAST) begin
			sh_q <= {sh_q[ISP_BYTE_W-2:0], sda_s};
		end
	end

	// software may rewrite this at any time; an address write loads it at once
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			own_q <= ISP_ADDR_RST;
		end else if (ev[EV_ADR_WR]) begin
			own_q <= adw_q;
		end
	end

	// ****************************************
	// address match
	// ****************************************
	logic ph2_q;
	logic hi_byte;
	logic match;
	logic is_addr;
	logic nm2;
	logic ua_set;

	assign hi_byte = sh_q[7:3] == ISP_TEN_HI;
	assign match = ph2_q ? (sh_q == own_q)
		: ((sh_q[7:1] == own_q[7:1]) && (!cfg[CFG_TEN] || hi_byte));
	assign is_addr = st_q == ISP_ADDR;
	// second address byte that misses: flagged, never loaded
	assign nm2 = fall8 & is_addr & ph2_q & ~match;
	assign ua_set = fall8 & is_addr & ((cfg[CFG_TEN] & ~ph2_q & match & ~sh_q[0]) | ph2_q);

	// ****************************************
	// ninth bit and state
	// ****************************************
	logic ack_ph_q;
	logic sw_ack_q;
	logic hw_ack_q;
	logic ack_drive;
	logic nm2_q;
	logic bf_q;
	logic rel_q;
	logic ua_q;
	logic hw_rel_clr;
	logic post_ack;
	logic ack_st_q;

	assign ack_drive = ack_ph_q & (sw_ack_q ? ~cfg[CFG_ACKD] : hw_ack_q);

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ack_ph_q <= 1'b0;
			sw_ack_q <= 1'b0;
			hw_ack_q <= 1'b0;
			nm2_q <= 1'b0;
		end else if (start_det || stop_det || fall9) begin
			ack_ph_q <= 1'b0;
			nm2_q <= 1'b0;
		end else if (fall8 && st_q != ISP_TX) begin
			ack_ph_q <= (is_addr & match) | (st_q == ISP_RX);
			nm2_q <= nm2;
			// holds hand the ack choice to software, 10-bit alike
			sw_ack_q <= is_addr ? cfg[CFG_ADDRESS_HOLD_ENABLE] : cfg[CFG_DATA_HOLD_ENABLE];
			hw_ack_q <= ~bf_q;
		end
	end

	assign post_ack = fall9 & ((st_q == ISP_TX) ? ~ack_st_q : ack_drive);

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ISP_IDLE;
			go_q <= ISP_IDLE;
			ph2_q <= 1'b0;
		end else if (stop_det) begin
			st_q <= ISP_IDLE;
		end else if (start_det) begin
			st_q <= ISP_ADDR;
			ph2_q <= 1'b0;
		end else if (fall8 && is_addr) begin
			if (!match && !ph2_q) begin
				st_q <= ISP_IDLE;
			end
			ph2_q <= ua_set & ~ph2_q;
			go_q <= (match && sh_q[0] && !ph2_q) ? ISP_TX : (ua_set && !ph2_q) ? ISP_ADDR : ISP_RX;
		end else if (fall9) begin
			if (st_q == ISP_TX) begin
				// master nack: let go of everything and wait for stop
				st_q <= ack_st_q ? ISP_IDLE : ISP_TX;
			end else begin
				st_q <= post_ack ? go_q : ISP_IDLE;
			end
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	logic ackt_q;
	logic rw_q;
	logic da_q;
	logic ss_q;
	logic ps_q;
	logic irq_q;
	logic irq_set;
	logic [ISP_BYTE_W-1:0] rx_q;
	logic rx_load;

	assign rx_load = fall8 & ((is_addr & match) | ((st_q == ISP_RX) & ~bf_q));

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ack_st_q <= 1'b0;
		end else if (rise9 && st_q == ISP_TX) begin
			ack_st_q <= sda_s;
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ackt_q <= 1'b0;
			rw_q <= 1'b0;
			da_q <= 1'b0;
		end else begin
			if (fall8 && st_q != ISP_TX) begin
				ackt_q <= 1'b1;
			end else if (fall9 || start_det) begin
				ackt_q <= 1'b0;
			end
			if (fall8 && is_addr && match && !ph2_q) begin
				rw_q <= sh_q[0];
			end
			if (fall8) begin
				da_q <= ~is_addr;
			end
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ss_q <= 1'b0;
			ps_q <= 1'b0;
		end else if (start_det) begin
			ss_q <= 1'b1;
			ps_q <= 1'b0;
		end else if (stop_det) begin
			ss_q <= 1'b0;
			ps_q <= 1'b1;
		end
	end

	// a read frees room; a load in the same cycle still wins
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			bf_q <= 1'b0;
			rx_q <= ISP_BUF_RST;
		end else begin
			if (ev[EV_BUF_RD]) begin
				bf_q <= 1'b0;
			end
			if (fall8 && st_q == ISP_TX) begin
				bf_q <= 1'b0;
			end
			if (rx_load) begin
				bf_q <= 1'b1;
				rx_q <= sh_q;
			end
			if (ev[EV_BUF_WR]) begin
				bf_q <= 1'b1;
				rx_q <= txw_q;
			end
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ua_q <= 1'b0;
		end else if (ua_set) begin
			ua_q <= 1'b1;
		end else if (ev[EV_ADR_WR]) begin
			ua_q <= 1'b0;
		end
	end

	// buffer full enters the read stretch decision only through the hardware address ack, when address hold is off
	assign hw_rel_clr = (fall8 & is_addr & match & cfg[CFG_ADDRESS_HOLD_ENABLE])
		| (fall8 & (st_q == ISP_RX) & cfg[CFG_DATA_HOLD_ENABLE])
		| (post_ack & (go_q == ISP_TX) & (st_q != ISP_TX))
		| (post_ack & (st_q == ISP_TX))
		| (post_ack & (st_q != ISP_TX) & cfg[CFG_STR]);

	assign irq_set = (start_det & cfg[CFG_SIRQ])
		| (fall8 & is_addr & match & cfg[CFG_ADDRESS_HOLD_ENABLE])
		| (fall8 & (st_q == ISP_RX) & cfg[CFG_DATA_HOLD_ENABLE])
		| post_ack
		| (fall9 & (st_q == ISP_TX))
		| (fall9 & nm2_q);

	// hardware clear beats a software set landing in the same cycle
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			rel_q <= 1'b1;
		end else if (hw_rel_clr) begin
			rel_q <= 1'b0;
		end else if (ev[EV_REL_CLR]) begin
			rel_q <= 1'b0;
		end else if (ev[EV_REL_SET]) begin
			rel_q <= 1'b1;
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else if (irq_set) begin
			irq_q <= 1'b1;
		end else if (ev[EV_IRQ_CLR]) begin
			irq_q <= 1'b0;
		end
	end

	assign stat_l = {rx_q, ua_q, ps_q, ss_q, da_q, rw_q, ackt_q, ack_st_q, bf_q, rel_q, irq_q};

	// ****************************************
	// pin drivers
	// ****************************************
	logic scl_oe_q;
	logic sda_oe_q;
	logic hold_req;

	// the update flag holds only outside the byte, after its ack
	assign hold_req = ~rel_q | (ua_q & (cnt_q == 4'h0));

	// only keep a line low that the master already pulled low
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			scl_oe_q <= 1'b0;
		end else begin
			scl_oe_q <= hold_req & (scl_oe_q | ~scl_s);
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			sda_oe_q <= 1'b0;
		end else begin
			// tx bits drive only while the loaded byte is unsent, so sda lets go after the 8th fall, scl low
			sda_oe_q <= ack_drive | ((st_q == ISP_TX) & bf_q & ~sh_q[7]);
		end
	end

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;

	// ****************************************
	// checks
	// ****************************************
	sequence s_tx_nack;
		fall9 && st_q == ISP_TX && ack_st_q;
	endsequence

	sequence s_read_ack;
		post_ack && go_q == ISP_TX && st_q != ISP_TX;
	endsequence

	a_hold_after_low: assert property (@(posedge link_clk) disable iff (!rstn)
		$rose(scl_oe_q) |-> !$past(scl_s)) else $error("clock pulled before sampled low");

	a_ua_holds: assert property (@(posedge link_clk) disable iff (!rstn)
		ua_q && cnt_q == 4'h0 && !scl_s && rel_q |=> scl_oe_q) else $error("update flag did not hold clock");

	a_start_irq: assert property (@(posedge link_clk) disable iff (!rstn)
		start_det && cfg[CFG_SIRQ] |=> irq_q && ss_q) else $error("start not flagged");

	a_ack_latch: assert property (@(posedge link_clk) disable iff (!rstn)
		rise9 && st_q == ISP_TX |=> ack_st_q == $past(sda_s)) else $error("master ack not latched");

	a_nack_idle: assert property (@(posedge link_clk) disable iff (!rstn)
		s_tx_nack |=> st_q == ISP_IDLE ##1 !sda_oe_q) else $error("nack did not release bus");

	a_read_hold: assert property (@(posedge link_clk) disable iff (!rstn)
		s_read_ack |=> !rel_q && irq_q && st_q == ISP_TX) else $error("read request not stretched");

	a_buf_write: assert property (@(posedge link_clk) disable iff (!rstn)
		ev[EV_BUF_WR] |=> bf_q && rx_q == $past(txw_q)) else $error("buffer write did not set full");

	a_addr_hold: assert property (@(posedge link_clk) disable iff (!rstn)
		fall8 && is_addr && match && cfg[CFG_ADDRESS_HOLD_ENABLE] |=> !rel_q && irq_q && ackt_q) else $error("address hold missed");

	a_data_hold: assert property (@(posedge link_clk) disable iff (!rstn)
		fall8 && st_q == ISP_RX && cfg[CFG_DATA_HOLD_ENABLE] |=> !rel_q && irq_q) else $error("data hold missed");

	a_nm2_flags: assert property (@(posedge link_clk) disable iff (!rstn)
		nm2 && !ev[EV_BUF_WR] && !bf_q |=> ua_q && !bf_q) else $error("mismatch not flagged");
endmodule // isp_slave

/* dv/isp_mstr.sv */
// behavioural two-wire bus master that drives the slave port from the far side
`timescale 1ns/1ps
module isp_mstr (
	// link timing and wire levels
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda,
	// open-drain pulls, high pulls the wire low
	output logic scl_low,
	output logic sda_low
);
	// ****************************************
	// timing and stretch handling
	// ****************************************
	localparam int HALF = 10;
	localparam int STALL_MAX = 400;
	int stall_err = 0;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic wait_half();
		repeat (HALF) @(posedge link_clk);
	endtask
	// a slave may stretch, so wait for the wire itself, but never forever
	task automatic scl_up();
		int n;
		n = 0;
		scl_low <= 1'b0;
		@(posedge link_clk);
		while (scl !== 1'b1 && n < STALL_MAX) begin
			@(posedge link_clk);
			n++;
		end
		if (n >= STALL_MAX) stall_err++;
	endtask
	// ****************************************
	// bus conditions and bits
	// ****************************************
	task automatic start();
		sda_low <= 1'b0;
		wait_half();
		scl_up();
		wait_half();
		sda_low <= 1'b1;
		wait_half();
		scl_low <= 1'b1;
		wait_half();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		wait_half();
		scl_up();
		wait_half();
		sda_low <= 1'b0;
		wait_half();
	endtask
	// data only moves while scl is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		wait_half();
		scl_up();
		r = sda;
		wait_half();
		scl_low <= 1'b1;
		wait_half();
	endtask
	task automatic write_bits(input logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
	endtask
	task automatic read_bits(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
	endtask
endmodule // isp_mstr

/* dv/testbench.sv */
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
module testbench;
	import isp_pkg::*;
	logic clock = 1'b0;
	logic link_clk = 1'b0;
	logic rstn = 1'b0;
	logic [ISP_CFG_W-1:0] cfg = '0;
	logic [ISP_EV_W-1:0] sw = '0;
	logic [7:0] buf_wdata = 8'h00;
	logic [7:0] addr_wdata = 8'h00;
	logic scl_oe, sda_oe, m_scl_low, m_sda_low, scl, sda;
	logic port_irq_flag, clock_release, buffer_full, ack_status, ack_timing_flag, read_write;
	logic data_not_address, start_seen, stop_seen, update_address_flag;
	logic [7:0] shift_buffer, dat, got, hi;
	logic [6:0] own;
	logic ack;
	int seed = 52;
	int mismatches = 0;
	int checked = 0;
	// pull-ups: a wire is low while anyone pulls it
	assign scl = !(m_scl_low || scl_oe);
	assign sda = !(m_sda_low || sda_oe);
	initial forever #2 clock = ~clock;
	initial begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	isp_slave i_isp_slave (.clock(clock), .rstn(rstn), .link_clk(link_clk), .scl_i(scl), .scl_o(),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .address_hold_enable(cfg[CFG_ADDRESS_HOLD_ENABLE]),
		.data_hold_enable(cfg[CFG_DATA_HOLD_ENABLE]), .stretch_enable(cfg[CFG_STR]), .start_irq_enable(cfg[CFG_SIRQ]),
		.ten_bit_mode(cfg[CFG_TEN]), .ack_data_value(cfg[CFG_ACKD]), .release_set(sw[EV_REL_SET]),
		.release_clear(sw[EV_REL_CLR]), .buf_write(sw[EV_BUF_WR]), .buf_wdata(buf_wdata),
		.buf_read(sw[EV_BUF_RD]), .addr_write(sw[EV_ADR_WR]), .addr_wdata(addr_wdata),
		.irq_clear(sw[EV_IRQ_CLR]), .port_irq_flag(port_irq_flag), .clock_release(clock_release),
		.buffer_full(buffer_full), .ack_status(ack_status), .ack_timing_flag(ack_timing_flag),
		.read_write(read_write), .data_not_address(data_not_address), .start_seen(start_seen),
		.stop_seen(stop_seen), .update_address_flag(update_address_flag), .shift_buffer(shift_buffer));
	isp_mstr i_isp_mstr (.link_clk(link_clk), .scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] abyte(input logic [6:0] a, input logic rw);
		return {a, rw};
	endfunction
	task automatic chk_bit(input logic g, input logic e, input string what);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, g, e);
		end
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string what);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	// strobes are spaced well apart so none is merged
	task automatic sw_op(input int k, input logic [7:0] v);
		@(posedge clock);
		if (k == EV_BUF_WR) buf_wdata <= v;
		if (k == EV_ADR_WR) addr_wdata <= v;
		sw[k] <= 1'b1;
		@(posedge clock);
		sw[k] <= 1'b0;
		repeat (10) @(posedge clock);
	endtask
	task automatic settle();
		repeat (16) @(posedge clock);
	endtask
	task automatic wrap_up();
		mismatches += i_isp_mstr.stall_err;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clock);
		mismatches++;
		wrap_up();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		settle();
		chk_bit(clock_release, 1'b1, "release at reset");
		chk_bit(scl_oe, 1'b0, "scl idle at reset");
		// 7-bit write with stretch enable and start interrupt
		own = 7'($random(seed));
		sw_op(EV_ADR_WR, abyte(own, 1'b0));
		@(posedge clock);
		cfg[CFG_SIRQ] <= 1'b1;
		cfg[CFG_STR] <= 1'b1;
		i_isp_mstr.start();
		settle();
		chk_bit(start_seen, 1'b1, "start seen");
		chk_bit(port_irq_flag, 1'b1, "start irq");
		sw_op(EV_IRQ_CLR, 8'h00);
		chk_bit(port_irq_flag, 1'b0, "irq cleared");
		i_isp_mstr.write_bits(abyte(own, 1'b0));
		i_isp_mstr.bit_io(1'b1, ack);
		settle();
		chk_bit(ack, 1'b0, "address ack");
		chk_bit(read_write, 1'b0, "write dir");
		chk_bit(data_not_address, 1'b0, "address kind");
		chk_byte(shift_buffer, abyte(own, 1'b0), "address byte");
		chk_bit(clock_release, 1'b0, "stretch after ack");
		chk_bit(scl_oe, 1'b1, "scl held");
		sw_op(EV_IRQ_CLR, 8'h00);
		sw_op(EV_BUF_RD, 8'h00);
		chk_bit(buffer_full, 1'b0, "read clears full");
		sw_op(EV_REL_SET, 8'h00);
		chk_bit(scl_oe, 1'b0, "release frees scl");
		dat = 8'($random(seed));
		i_isp_mstr.write_bits(dat);
		i_isp_mstr.bit_io(1'b1, ack);
		settle();
		chk_bit(data_not_address, 1'b1, "data kind");
		chk_byte(shift_buffer, dat, "data byte");
		chk_bit(buffer_full, 1'b1, "data full");
		chk_bit(port_irq_flag, 1'b1, "data irq");
		chk_bit(clock_release, 1'b0, "data stretch");
		chk_bit(scl_oe, 1'b1, "data scl held");
		sw_op(EV_BUF_RD, 8'h00);
		sw_op(EV_REL_SET, 8'h00);
		i_isp_mstr.stop();
		settle();
		chk_bit(stop_seen, 1'b1, "stop seen");
		// release cleared while scl is high must not pull it
		sw_op(EV_REL_CLR, 8'h00);
		chk_bit(clock_release, 1'b0, "release cleared");
		chk_bit(scl_oe, 1'b0, "no pull while high");
		sw_op(EV_REL_SET, 8'h00);
		// read with address hold, buffer read before the ninth fall
		sw_op(EV_IRQ_CLR, 8'h00);
		@(posedge clock);
		cfg <= '0;
		cfg[CFG_ADDRESS_HOLD_ENABLE] <= 1'b1;
		i_isp_mstr.start();
		settle();
		chk_bit(port_irq_flag, 1'b0, "no start irq");
		i_isp_mstr.write_bits(abyte(own, 1'b1));
		settle();
		chk_bit(clock_release, 1'b0, "address hold");
		chk_bit(port_irq_flag, 1'b1, "address hold irq");
		chk_bit(scl_oe, 1'b1, "address hold scl");
		chk_bit(ack_timing_flag, 1'b1, "ack timing");
		sw_op(EV_IRQ_CLR, 8'h00);
		sw_op(EV_BUF_RD, 8'h00);
		sw_op(EV_REL_SET, 8'h00);
		i_isp_mstr.bit_io(1'b1, ack);
		settle();
		chk_bit(ack, 1'b0, "software ack level");
		chk_bit(read_write, 1'b1, "read dir");
		chk_bit(clock_release, 1'b0, "read stretch");
		chk_bit(port_irq_flag, 1'b1, "read irq");
		chk_bit(scl_oe, 1'b1, "read scl held");
		for (int k = 0; k < 2; k++) begin
			dat = 8'($random(seed));
			sw_op(EV_IRQ_CLR, 8'h00);
			sw_op(EV_BUF_WR, dat);
			chk_bit(buffer_full, 1'b1, "write sets full");
			sw_op(EV_REL_SET, 8'h00);
			i_isp_mstr.read_bits(got);
			i_isp_mstr.bit_io(k == 1, ack);
			settle();
			chk_byte(got, dat, "sent byte");
			chk_bit(ack_status, k == 1, "master ack");
			chk_bit(port_irq_flag, 1'b1, "byte irq");
			chk_bit(scl_oe, k == 0, "hold only on ack");
			chk_bit(sda_oe, 1'b0, "sda let go");
		end
		i_isp_mstr.stop();
		// data hold with a software nack
		@(posedge clock);
		cfg <= '0;
		cfg[CFG_DATA_HOLD_ENABLE] <= 1'b1;
		i_isp_mstr.start();
		i_isp_mstr.write_bits(abyte(own, 1'b0));
		i_isp_mstr.bit_io(1'b1, ack);
		settle();
		sw_op(EV_IRQ_CLR, 8'h00);
		sw_op(EV_BUF_RD, 8'h00);
		i_isp_mstr.write_bits(8'($random(seed)));
		settle();
		chk_bit(clock_release, 1'b0, "data hold");
		chk_bit(scl_oe, 1'b1, "data hold scl");
		chk_bit(port_irq_flag, 1'b1, "data hold irq");
		@(posedge clock);
		cfg[CFG_ACKD] <= 1'b1;
		sw_op(EV_REL_SET, 8'h00);
		i_isp_mstr.bit_io(1'b1, ack);
		chk_bit(ack, 1'b1, "software nack");
		sw_op(EV_BUF_RD, 8'h00);
		chk_bit(buffer_full, 1'b0, "nacked byte read");
		i_isp_mstr.stop();
		// ten-bit address, low byte mismatch
		@(posedge clock);
		cfg <= '0;
		cfg[CFG_TEN] <= 1'b1;
		hi = abyte({ISP_TEN_HI, 2'($random(seed))}, 1'b0);
		sw_op(EV_ADR_WR, hi);
		sw_op(EV_IRQ_CLR, 8'h00);
		i_isp_mstr.start();
		i_isp_mstr.write_bits(hi);
		i_isp_mstr.bit_io(1'b1, ack);
		settle();
		chk_bit(ack, 1'b0, "high byte ack");
		chk_bit(update_address_flag, 1'b1, "update flag");
		chk_bit(port_irq_flag, 1'b1, "high byte irq");
		chk_bit(clock_release, 1'b1, "release untouched");
		chk_bit(scl_oe, 1'b1, "update hold");
		sw_op(EV_IRQ_CLR, 8'h00);
		sw_op(EV_BUF_RD, 8'h00);
		dat = 8'($random(seed));
		sw_op(EV_ADR_WR, dat);
		chk_bit(scl_oe, 1'b0, "address write frees scl");
		i_isp_mstr.write_bits(dat ^ 8'h01);
		i_isp_mstr.bit_io(1'b1, ack);
		settle();
		chk_bit(ack, 1'b1, "low mismatch nack");
		chk_bit(update_address_flag, 1'b1, "mismatch update");
		chk_bit(port_irq_flag, 1'b1, "mismatch irq");
		chk_bit(buffer_full, 1'b0, "mismatch not full");
		chk_bit(clock_release, 1'b1, "mismatch release");
		sw_op(EV_ADR_WR, hi);
		i_isp_mstr.stop();
		settle();
		wrap_up();
	end
endmodule // testbench
